// ===== hw/dio_cfg_regs.sv
// Input and output configuration registers with pattern result capture.
`timescale 1ns/1ps
`default_nettype none
module dio_cfg_regs (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_b,
  input  wire dio_pkg::dio_req_t i_req,
  output logic [15:0]          o_rdata,
  input  wire logic            i_txenable_pin,
  input  wire logic [15:0]     i_alarm_mask_reg,
  input  wire logic            i_pattern_test_en,
  input  wire logic [15:0]     i_pattern_mismatch,
  input  wire logic            i_sclk_gone,
  input  wire logic            i_dclk_gone,
  input  wire logic            i_fifo_collision,
  input  wire logic [15:0]     i_sample,
  output logic [15:0]          o_sample,
  output dio_pkg::dio_ctrl_t   o_ctrl,
  output logic                 o_tx_enable,
  output logic                 o_output_gone
);
  import dio_pkg::*;

  // Reverses the order of a 16-bit word.
  function automatic logic [15:0] rev16(input logic [15:0] d);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      r[k] = d[15-k];
    end
    return r;
  endfunction

  logic [15:0] mode_ff;      // Input mode register.
  logic [15:0] scale_ff;     // Output scale register.
  logic [15:0] fail_ff;      // Sticky pattern mismatch bits.
  logic [15:0] rdata_ff;     // Registered read data.
  logic [15:0] sample_ff;    // Registered output sample.
  logic        gone_ff;      // Registered shutdown alarm.
  logic [15:0] nxt_fail;     // Next mismatch bits.
  logic [15:0] nxt_rdata;    // Next read data.
  logic [15:0] nxt_sample;   // Next output sample.

  // Address decode of the three registers.
  wire         hit_mode  = i_req.addr == IDX_INPUT_MODE;
  wire         hit_scale = i_req.addr == IDX_OUTPUT_SCALE;
  wire         hit_fail  = i_req.addr == IDX_PATTERN_FAIL;
  wire         wr_mode   = i_req.wr & hit_mode;
  wire         wr_scale  = i_req.wr & hit_scale;
  wire         wr_fail   = i_req.wr & hit_fail;

  // reserved read zero
  // Reserved bits never store, so reads show their zero defaults.
  wire [15:0]  mode_wv   = i_req.wdata & WR_INPUT_MODE;
  wire [15:0]  scale_wv  = i_req.wdata & WR_OUTPUT_SCALE;

  wire         sclk_shut = mode_ff[BIT_SCLK_SHUT] & i_sclk_gone &
                           ~i_alarm_mask_reg[MASK_SCLK_GONE];
  wire         dclk_shut = mode_ff[BIT_DCLK_SHUT] & i_dclk_gone &
                           ~i_alarm_mask_reg[MASK_DCLK_GONE];
  wire         coll_shut = mode_ff[BIT_COLL_SHUT] & i_fifo_collision &
                           ~i_alarm_mask_reg[MASK_COLL];
  // The combined alarm only acts while its own mask bit is clear.
  wire         nxt_gone  = (sclk_shut | dclk_shut | coll_shut) &
                           ~i_alarm_mask_reg[MASK_OUT_GONE];

  wire [15:0]  ordered   = mode_ff[BIT_REV_BUS] ? rev16(i_sample) : i_sample;
  // sample format
  // Two's complement is turned to offset binary by inverting the sign bit.
  wire [15:0]  offset_bin = {ordered[15] ^ mode_ff[BIT_TWOS], ordered[14:0]};

  assign nxt_sample = nxt_gone ? MID_SCALE : offset_bin;

  // sticky mismatch capture
  // A mismatch in the clearing cycle still sets its bit.
  assign nxt_fail = (wr_fail ? 16'h0000 : fail_ff) |
                    (i_pattern_test_en ? i_pattern_mismatch : 16'h0000);

  // Read multiplexer; unmapped indices read zero.
  assign nxt_rdata = hit_mode  ? mode_ff  :
                     hit_scale ? scale_ff :
                     hit_fail  ? fail_ff  : 16'h0000;

  // Writable configuration registers with their reset values.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff  <= RST_INPUT_MODE;
      scale_ff <= RST_OUTPUT_SCALE;
    end else begin
      if (wr_mode) begin
        mode_ff <= mode_wv;
      end
      if (wr_scale) begin
        scale_ff <= scale_wv;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    fail_ff <= nxt_fail;
  end

  // Read data, output sample and alarm registers.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff  <= 16'h0000;
      sample_ff <= MID_SCALE;
      gone_ff   <= 1'b0;
    end else begin
      if (i_req.rd) begin
        rdata_ff <= nxt_rdata;
      end
      sample_ff <= nxt_sample;
      gone_ff   <= nxt_gone;
    end
  end

  assign o_rdata       = rdata_ff;
  assign o_sample      = sample_ff;
  assign o_output_gone = gone_ff;

  assign o_ctrl.wide_input_sel     = mode_ff[BIT_WIDE_IN];
  assign o_ctrl.four_wire_port_sel = mode_ff[BIT_FOUR_WIRE];
  assign o_ctrl.mixer_en           = mode_ff[BIT_MIXER_EN];
  assign o_ctrl.mixer_boost        = mode_ff[BIT_MIX_BOOST];
  assign o_ctrl.nco_en             = mode_ff[BIT_NCO_EN];
  assign o_ctrl.bus_reverse        = mode_ff[BIT_REV_BUS];
  assign o_ctrl.twos_fmt           = mode_ff[BIT_TWOS];
  assign o_ctrl.full_scale_code    = scale_ff[FS_MSB:FS_LSB];

  assign o_tx_enable = (scale_ff[BIT_SW_TX] | i_txenable_pin) &
                       ~i_pattern_test_en;

  // Checks of the register behaviour.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_wr_scale;
    wr_scale;
  endsequence
  sequence s_scale_seen;
    ##1 o_ctrl.full_scale_code == $past(i_req.wdata[FS_MSB:FS_LSB]);
  endsequence

  property p_wide;
    wr_mode |=> o_ctrl.wide_input_sel == $past(i_req.wdata[BIT_WIDE_IN]);
  endproperty
  a_wide: assert property (p_wide) else $error("Width bit wrong.");

  property p_sclk;
    i_sclk_gone & mode_ff[BIT_SCLK_SHUT] & ~i_alarm_mask_reg[MASK_SCLK_GONE]
      & ~i_alarm_mask_reg[MASK_OUT_GONE] |=> o_output_gone;
  endproperty
  a_sclk: assert property (p_sclk) else $error("No clock shutdown.");

  property p_dclk;
    i_dclk_gone & mode_ff[BIT_DCLK_SHUT] & ~i_alarm_mask_reg[MASK_DCLK_GONE]
      & ~i_alarm_mask_reg[MASK_OUT_GONE] |=> o_output_gone;
  endproperty
  a_dclk: assert property (p_dclk) else $error("No data clock stop.");

  property p_coll;
    !i_fifo_collision & !i_sclk_gone & !i_dclk_gone |=> !o_output_gone;
  endproperty
  a_coll: assert property (p_coll) else $error("Spurious shutdown.");

  property p_four;
    wr_mode |=> o_ctrl.four_wire_port_sel == $past(i_req.wdata[BIT_FOUR_WIRE]);
  endproperty
  a_four: assert property (p_four) else $error("Port width wrong.");

  property p_scale;
    s_wr_scale |-> s_scale_seen;
  endproperty
  a_scale: assert property (p_scale) else $error("Scale code wrong.");

  property p_tx;
    o_tx_enable == ((scale_ff[BIT_SW_TX] | i_txenable_pin) &
                    !i_pattern_test_en);
  endproperty
  a_tx: assert property (p_tx) else $error("Transmit enable wrong.");

  property p_sticky;
    i_pattern_test_en & i_pattern_mismatch[0] |=> fail_ff[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Mismatch lost.");

  property p_mid;
    o_output_gone |-> o_sample == MID_SCALE;
  endproperty
  a_mid: assert property (p_mid) else $error("Not mid-scale.");

  property p_rsvd;
    (mode_ff & ~WR_INPUT_MODE) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved bit set.");

  // A live collision with both of its mask bits clear must shut the outputs.
  property p_coll_on;
    i_fifo_collision & mode_ff[BIT_COLL_SHUT] & ~i_alarm_mask_reg[MASK_COLL]
      & ~i_alarm_mask_reg[MASK_OUT_GONE] |=> o_output_gone;
  endproperty
  a_coll_on: assert property (p_coll_on) else $error("No buffer stop.");

  // The mixer enable follows the written bit from the next edge on.
  property p_mixer;
    wr_mode |=> o_ctrl.mixer_en == $past(i_req.wdata[BIT_MIXER_EN]);
  endproperty
  a_mixer: assert property (p_mixer) else $error("Mixer enable wrong.");

  // The gain boost follows the written bit from the next edge on.
  property p_boost;
    wr_mode |=> o_ctrl.mixer_boost == $past(i_req.wdata[BIT_MIX_BOOST]);
  endproperty
  a_boost: assert property (p_boost) else $error("Mixer boost wrong.");

  // The oscillator enable follows the written bit from the next edge on.
  property p_nco;
    wr_mode |=> o_ctrl.nco_en == $past(i_req.wdata[BIT_NCO_EN]);
  endproperty
  a_nco: assert property (p_nco) else $error("NCO enable wrong.");

  // A running pattern test keeps the outputs off whatever the enables say.
  property p_toff;
    i_pattern_test_en |-> !o_tx_enable;
  endproperty
  a_toff: assert property (p_toff) else $error("Outputs not off.");

  // A host write with no live mismatch leaves every result bit clear.
  property p_clear;
    wr_fail & !i_pattern_test_en |=> fail_ff == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("Results not cleared.");

endmodule
`default_nettype wire

// ===== include/dio_pkg.sv
// Package with register map, field layout and carriers of the config bank.
// Behaviour
// - Width bit picks word or byte input.
// - Sample clock loss shuts outputs when enabled.
// - Input clock loss shuts outputs when enabled.
// - Buffer collision shuts outputs when enabled.
// - Port width bit picks four or three wires.
// - Mixer runs only while its enable set.
// - Boost bit adds 6dB mixer gain.
// - Oscillator runs only while enabled.
// - Flip bit reverses input bus order.
// - Format bit picks twos complement or offset.
// - Four bit code sets full scale current.
// - Transmit enable is software OR pin.
// - Result bits flag mismatches per data line.
// - Results unreset; host write clears them.
// - Pattern test starts and silences outputs.
// - Shutdown alarm forces mid-scale output code.
`default_nettype none
package dio_pkg;

  // Register indices as printed.
  localparam logic [6:0]  IDX_INPUT_MODE   = 7'h02;
  localparam logic [6:0]  IDX_OUTPUT_SCALE = 7'h03;
  localparam logic [6:0]  IDX_PATTERN_FAIL = 7'h04;

  // Reset values.
  localparam logic [15:0] RST_INPUT_MODE   = 16'h7000;
  localparam logic [15:0] RST_OUTPUT_SCALE = 16'hf000;

  // Writable bits; all others are reserved and read as zero.
  localparam logic [15:0] WR_INPUT_MODE    = 16'hf0fa;
  localparam logic [15:0] WR_OUTPUT_SCALE  = 16'hf001;

  // Field positions of the input mode register.
  localparam int BIT_WIDE_IN    = 15;
  localparam int BIT_SCLK_SHUT  = 14;
  localparam int BIT_DCLK_SHUT  = 13;
  localparam int BIT_COLL_SHUT  = 12;
  localparam int BIT_FOUR_WIRE  = 7;
  localparam int BIT_MIXER_EN   = 6;
  localparam int BIT_MIX_BOOST  = 5;
  localparam int BIT_NCO_EN     = 4;
  localparam int BIT_REV_BUS    = 3;
  localparam int BIT_TWOS       = 1;

  // Field positions of the output scale register.
  localparam int BIT_SW_TX      = 0;
  localparam int FS_MSB         = 15;
  localparam int FS_LSB         = 12;

  // Field positions in the alarm mask register kept by the host.
  localparam int MASK_OUT_GONE  = 8;
  localparam int MASK_DCLK_GONE = 9;
  localparam int MASK_SCLK_GONE = 10;
  localparam int MASK_COLL      = 13;

  // Mid-scale code driven while the outputs are shut off.
  localparam logic [15:0] MID_SCALE        = 16'h8000;

  // Register access request from the serial port.
  typedef struct packed {
    logic        wr;    // Write strobe, one cycle.
    logic        rd;    // Read strobe, one cycle.
    logic [6:0]  addr;  // Register index.
    logic [15:0] wdata; // Write data.
  } dio_req_t;

  // Decoded controls that steer the rest of the converter.
  typedef struct packed {
    logic       wide_input_sel;
    logic       four_wire_port_sel;
    logic       mixer_en;
    logic       mixer_boost;
    logic       nco_en;
    logic       bus_reverse;
    logic       twos_fmt;
    logic [3:0] full_scale_code;
  } dio_ctrl_t;

endpackage
`default_nettype wire

// ===== test/dio_host_model.sv
// Host model that drives the register port and holds the alarm mask.
`timescale 1ns/1ps
`default_nettype none
module dio_host_model (
  input  wire logic         i_sys_clk,
  input  wire logic [15:0]  i_rdata,
  output dio_pkg::dio_req_t o_req,
  output logic [15:0]       o_alarm_mask
);
  import dio_pkg::*;
  initial begin
    o_req = '0;
    o_alarm_mask = 16'h0000;
  end
  // One write, held across one rising edge, then released.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_sys_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One read; data is taken once the answer edge has passed.
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge i_sys_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge i_sys_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dio_pkg::*;
  logic        clk, rst_b, pin, ten, sg, dg, fc, tx, gone;
  logic [15:0] mism, smp, osmp, rdata, mask;
  dio_req_t    req;
  dio_ctrl_t   ctrl;
  int          num_errors, checks_done;
  dio_cfg_regs uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req),
    .o_rdata(rdata), .i_txenable_pin(pin), .i_alarm_mask_reg(mask),
    .i_pattern_test_en(ten), .i_pattern_mismatch(mism), .i_sclk_gone(sg),
    .i_dclk_gone(dg), .i_fifo_collision(fc), .i_sample(smp),
    .o_sample(osmp), .o_ctrl(ctrl), .o_tx_enable(tx), .o_output_gone(gone));
  dio_host_model host (.i_sys_clk(clk), .i_rdata(rdata), .o_req(req),
    .o_alarm_mask(mask));
  // Free running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic t_reset();
    rchk(IDX_INPUT_MODE, 16'h7000);
    rchk(IDX_OUTPUT_SCALE, 16'hf000);
    chk(16'(ctrl), 16'h000f);
    chk(16'(gone), 16'h0000);
  endtask
  // Each control bit alone, then all ones to expose reserved bits.
  task automatic t_fields();
    int bp[7] = '{15, 7, 6, 5, 4, 3, 1};
    for (int i = 0; i < 7; i++) begin
      host.wr(IDX_INPUT_MODE, 16'(1) << bp[i]);
      rchk(IDX_INPUT_MODE, 16'(1) << bp[i]);
      chk(16'(ctrl), (16'h0400 >> i) | 16'h000f);
    end
    host.wr(IDX_INPUT_MODE, 16'hffff);
    rchk(IDX_INPUT_MODE, 16'hf0fa);
  endtask
  // Scale code and every software, pin and test enable combination.
  task automatic t_scale();
    host.wr(IDX_OUTPUT_SCALE, 16'hffff);
    rchk(IDX_OUTPUT_SCALE, 16'hf001);
    for (int i = 0; i < 8; i++) begin
      {ten, pin} = 2'(i >> 1);
      host.wr(IDX_OUTPUT_SCALE, {4'(i + 3), 11'h000, i[0]});
      chk(16'(ctrl.full_scale_code), 16'(i + 3));
      chk(16'(tx), 16'((i[0] | pin) & ~ten));
    end
    {ten, pin} = 2'b00;
  endtask
  task automatic t_data();
    smp = 16'h1235;
    host.wr(IDX_INPUT_MODE, 16'h0000);
    @(negedge clk);
    chk(osmp, 16'h1235);
    host.wr(IDX_INPUT_MODE, 16'h0008);
    @(negedge clk);
    chk(osmp, 16'hac48);
    host.wr(IDX_INPUT_MODE, 16'h0002);
    @(negedge clk);
    chk(osmp, 16'h9235);
  endtask
  // Each loss source: disabled, masked twice, then live.
  task automatic t_shut();
    int mb[3] = '{MASK_SCLK_GONE, MASK_DCLK_GONE, MASK_COLL};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      host.wr(IDX_INPUT_MODE, 16'h7000 ^ (16'h4000 >> i));
      {sg, dg, fc} = 3'b100 >> i;
      repeat (2) @(negedge clk);
      chk(16'(gone), 16'h0000);
      host.o_alarm_mask = 16'h0100;
      host.wr(IDX_INPUT_MODE, 16'h7000);
      repeat (2) @(negedge clk);
      chk(16'(gone), 16'h0000);
      host.o_alarm_mask = 16'(1) << mb[i];
      repeat (2) @(negedge clk);
      chk(16'(gone), 16'h0000);
      host.o_alarm_mask = 16'h0000;
      repeat (2) @(negedge clk);
      chk(16'(gone), 16'h0001);
      chk(osmp, MID_SCALE);
      {sg, dg, fc} = 3'b000;
    end
    do_reset();
  endtask
  // Result bits stick until a write clears them; unmapped index is empty.
  task automatic t_pattern();
    host.wr(IDX_PATTERN_FAIL, 16'h1234);
    rchk(IDX_PATTERN_FAIL, 16'h0000);
    ten = 1'b1;
    mism = 16'h8001;
    @(negedge clk);
    mism = 16'h0000;
    rchk(IDX_PATTERN_FAIL, 16'h8001);
    rchk(IDX_PATTERN_FAIL, 16'h8001);
    host.wr(IDX_PATTERN_FAIL, 16'h0000);
    ten = 1'b0;
    rchk(IDX_PATTERN_FAIL, 16'h0000);
    host.wr(7'h05, 16'hffff);
    rchk(7'h05, 16'h0000);
  endtask
  initial begin
    rst_b = 1'b0;
    {pin, ten, sg, dg, fc} = 5'b00000;
    mism = 16'h0000;
    smp = 16'h0000;
    do_reset();
    t_reset();
    t_fields();
    t_scale();
    t_data();
    t_shut();
    t_pattern();
    print_verdict();
  end
  // Watchdog well beyond the roughly 160 cycles the tests need.
  initial begin
    #(25 * 5000);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
